/* src/csia_pkg.sv */
// Package with constants and carrier types of the stack and indirect addressing block
package csia_pkg;
    localparam int STACK_DEPTH = 16;
    localparam int PC_W = 16;
    localparam logic [3:0] SP_RESET = 4'h0;
    localparam logic [3:0] SP_TOP = 4'hf;
    localparam logic AVAIL_RESET = 1'b1;
    // Data-space addresses of the two indirect windows
    localparam logic [7:0] WIN0_ADDR = 8'h00;
    localparam logic [7:0] WIN1_ADDR = 8'h08;
    // Pointer mode encodings
    localparam logic [1:0] MODE_DEC = 2'b00;
    localparam logic [1:0] MODE_INC = 2'b01;
    // APB register byte offsets
    localparam logic [7:0] OFS_PTR0 = 8'h00;
    localparam logic [7:0] OFS_PTR1 = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_BANK = 8'h10;
    // Reset values of software registers
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] MODES_RESET = 4'hf;
    localparam logic [7:0] BANK_RESET = 8'h00;

    typedef enum logic [1:0] {CSIA_OP_NONE, CSIA_OP_PUSH, CSIA_OP_POP} csia_stk_op_t;

    // Stack request from the sequencer
    typedef struct packed {
        logic push;
        logic pop;
        logic [15:0] pc;
    } csia_stk_req_t;

    // Indirect access request from the decoder
    typedef struct packed {
        logic rd;
        logic wr;
        logic win;
        logic [7:0] wdata;
    } csia_ind_req_t;

    // Memory-side port towards the data RAM
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] bank;
        logic [7:0] wdata;
    } csia_mem_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } csia_apb_rsp_t;
endpackage

/* src/csia_stack.sv */
// Sixteen-entry circular return stack with its availability flag
`timescale 1ns/1ps
module csia_stack (
    input wire logic clk,
    input wire logic reset,
    input wire csia_pkg::csia_stk_req_t req,
    output logic [15:0] top,
    output logic avail,
    output logic [3:0] sp
);
    import csia_pkg::*;

    logic [PC_W-1:0] mem_q [STACK_DEPTH];
    logic [3:0] sp_q;
    logic avail_q;
    logic locked_q;
    logic popped_first_q;
    logic pushed_q;
    csia_stk_op_t op;

    // Push wins if both are requested in one cycle
    always_comb begin
        op = CSIA_OP_NONE;
        if (req.push) begin
            op = CSIA_OP_PUSH;
        end else if (req.pop) begin
            op = CSIA_OP_POP;
        end
    end

    // Storage: pointer names the next free slot, overwrite oldest on wrap
    always_ff @(posedge clk) begin
        if (op == CSIA_OP_PUSH) begin
            mem_q[sp_q] <= req.pc;
        end
    end

    // Stack pointer, circular
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sp_q <= SP_RESET;
        end else begin
            case (op)
                CSIA_OP_PUSH: sp_q <= sp_q + 4'h1;
                CSIA_OP_POP: sp_q <= sp_q - 4'h1;
                default: sp_q <= sp_q;
            endcase
        end
    end

    // Tracks pop-before-push after reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pushed_q <= 1'b0;
            popped_first_q <= 1'b0;
        end else begin
            if (op == CSIA_OP_PUSH) begin
                pushed_q <= 1'b1;
                popped_first_q <= 1'b0;
            end else if (op == CSIA_OP_POP && !pushed_q) begin
                popped_first_q <= 1'b1;
            end
        end
    end

    // Lock: rollover F to 0, or the first push after an initial underflow
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            locked_q <= 1'b0;
        end else if (op == CSIA_OP_PUSH && (sp_q == SP_TOP || popped_first_q)) begin
            locked_q <= 1'b1;
        end
    end

    // Availability flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avail_q <= AVAIL_RESET;
        end else begin
            avail_q <= 1'b1;
            if (op == CSIA_OP_PUSH) begin
                if (sp_q + 4'h1 == SP_TOP || sp_q == SP_TOP || popped_first_q || locked_q) begin
                    avail_q <= 1'b0;
                end
            end else if (op == CSIA_OP_POP) begin
                if (sp_q - 4'h1 == SP_TOP || locked_q) begin
                    avail_q <= 1'b0;
                end
            end else if (sp_q == SP_TOP || locked_q) begin
                avail_q <= 1'b0;
            end
        end
    end

    assign top = mem_q[sp_q - 4'h1];
    assign avail = avail_q;
    assign sp = sp_q;
endmodule

/* src/csia_core.sv */
// Return stack and indirect data addressing for the processor core
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module csia_core (
    input wire logic CLK,
    input wire logic RESET,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Stack requests from sequencer
    input wire csia_pkg::csia_stk_req_t STK_REQ,
    output logic [15:0] STK_TOP,
    output logic STACK_AVAILABLE_FLAG,
    // Indirect access requests from decoder
    input wire csia_pkg::csia_ind_req_t IND_REQ,
    output logic [7:0] IND_RDATA,
    output logic IND_VALID,
    output logic IND_ZERO_SET,
    // Data memory side
    output csia_pkg::csia_mem_req_t MEM_REQ,
    input wire logic [7:0] MEM_RDATA
);
    import csia_pkg::*;

    logic [7:0] ptr0_q;
    logic [7:0] ptr1_q;
    logic [7:0] ptr0_d;
    logic [7:0] ptr1_d;
    logic [3:0] modes_q;
    logic [7:0] bank_q;
    logic [7:0] rdata_q;
    logic valid_q;
    logic zero_q;
    logic [31:0] prdata_q;
    logic [7:0] sel_ptr;
    logic [1:0] sel_mode;
    logic blocked;
    logic apb_wr;
    logic apb_rd;
    logic ind_act;

    // Post-access pointer update by mode
    function automatic logic [7:0] next_ptr(input logic [7:0] p, input logic [1:0] m);
        case (m)
            MODE_DEC: next_ptr = p - 8'h01;
            MODE_INC: next_ptr = p + 8'h01;
            default: next_ptr = p;
        endcase
    endfunction

    // True when an address names one of the windows
    function automatic logic is_window(input logic [7:0] a);
        is_window = (a == WIN0_ADDR) || (a == WIN1_ADDR);
    endfunction

    // Return stack; its pointer never reaches the register map
    csia_stack u_stack (
        .clk(CLK),
        .reset(RESET),
        .req(STK_REQ),
        .top(STK_TOP),
        .avail(STACK_AVAILABLE_FLAG),
        .sp()
    );

    // The high program latch lives in the sequencer and is not wired here

    // Pick pointer and mode for the requested window
    always_comb begin
        if (IND_REQ.win) begin
            sel_ptr = ptr1_q;
            sel_mode = modes_q[3:2];
        end else begin
            sel_ptr = ptr0_q;
            sel_mode = modes_q[1:0];
        end
    end

    assign ind_act = IND_REQ.rd || IND_REQ.wr;
    assign blocked = (sel_ptr == 8'h00) || is_window(sel_ptr);
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign apb_rd = PSEL && !PENABLE && !PWRITE;

    // Memory request goes straight through in the same cycle
    always_comb begin
        MEM_REQ.addr = sel_ptr;
        MEM_REQ.bank = bank_q;
        MEM_REQ.wdata = IND_REQ.wdata;
        MEM_REQ.rd = IND_REQ.rd && !blocked;
        MEM_REQ.wr = IND_REQ.wr && !blocked;
    end

    // Read result and zero-flag request, registered
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_q <= 8'h00;
            valid_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            valid_q <= ind_act;
            zero_q <= IND_REQ.rd && blocked;
            if (IND_REQ.rd) begin
                rdata_q <= blocked ? 8'h00 : MEM_RDATA;
            end
        end
    end

    // Pointer next values: software write, else auto update
    always_comb begin
        ptr0_d = ptr0_q;
        ptr1_d = ptr1_q;
        if (apb_wr && PADDR == OFS_PTR0) begin
            ptr0_d = PWDATA[7:0];
        end else if (ind_act && !IND_REQ.win) begin
            ptr0_d = next_ptr(ptr0_q, modes_q[1:0]);
        end
        if (apb_wr && PADDR == OFS_PTR1) begin
            ptr1_d = PWDATA[7:0];
        end else if (ind_act && IND_REQ.win) begin
            ptr1_d = next_ptr(ptr1_q, modes_q[3:2]);
        end
    end

    // Pointer registers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ptr0_q <= PTR_RESET;
            ptr1_q <= PTR_RESET;
        end else begin
            ptr0_q <= ptr0_d;
            ptr1_q <= ptr1_d;
        end
    end

    // Mode and bank registers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            modes_q <= MODES_RESET;
            bank_q <= BANK_RESET;
        end else if (apb_wr) begin
            if (PADDR == OFS_CTRL) begin
                modes_q <= PWDATA[3:0];
            end
            if (PADDR == OFS_BANK) begin
                bank_q <= PWDATA[7:0];
            end
        end
    end

    // APB read data captured in setup phase
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_rd) begin
            case (PADDR)
                OFS_PTR0: prdata_q <= {24'h00_0000, ptr0_q};
                OFS_PTR1: prdata_q <= {24'h00_0000, ptr1_q};
                OFS_CTRL: prdata_q <= {28'h000_0000, modes_q};
                OFS_STAT: prdata_q <= {31'h0000_0000, STACK_AVAILABLE_FLAG};
                OFS_BANK: prdata_q <= {24'h00_0000, bank_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Unmapped or misaligned addresses answer with an error
    always_comb begin
        PREADY = 1'b1;
        PSLVERR = PSEL && PENABLE && !(PADDR == OFS_PTR0 || PADDR == OFS_PTR1 ||
            PADDR == OFS_CTRL || PADDR == OFS_STAT || PADDR == OFS_BANK ||
            (PWRITE && PADDR == OFS_STAT));
        PSLVERR = PSLVERR && !(PWRITE && PADDR == OFS_STAT);
    end

    assign PRDATA = prdata_q;
    assign IND_RDATA = rdata_q;
    assign IND_VALID = valid_q;
    assign IND_ZERO_SET = zero_q;
endmodule

/* sim/csia_ram_model.sv */
// Data memory model behind the core's memory port
`timescale 1ns/1ps
module csia_ram_model (
    input wire logic clk,
    input wire csia_pkg::csia_mem_req_t req,
    output logic [7:0] rdata
);
    import csia_pkg::*;
    logic [7:0] mem [256];
    // Known contents: each byte is its address scrambled
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5c;
        end
    end
    // Same-cycle read; an idle port shows inverted data, never a stale byte
    assign rdata = req.rd ? mem[req.addr] : ~mem[req.addr];
    // Write lands at the request edge
    always @(posedge clk) begin
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
        end
    end
endmodule

/* sim/csia_core_asserts.sv */
// Checker of the stack flag and indirect port
`timescale 1ns/1ps
module csia_core_asserts (
    input wire logic CLK,
    input wire logic RESET,
    input wire csia_pkg::csia_stk_req_t STK_REQ,
    input wire logic [15:0] STK_TOP,
    input wire logic STACK_AVAILABLE_FLAG,
    input wire csia_pkg::csia_ind_req_t IND_REQ,
    input wire logic [7:0] IND_RDATA,
    input wire logic IND_VALID,
    input wire logic IND_ZERO_SET,
    input wire csia_pkg::csia_mem_req_t MEM_REQ,
    input wire logic [7:0] MEM_RDATA
);
    import csia_pkg::*;
    logic [3:0] sp_q;
    logic lock_q;
    // Shadow pointer; locked once a push leaves F
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sp_q <= SP_RESET;
            lock_q <= 1'b0;
        end else if (STK_REQ.push) begin
            sp_q <= sp_q + 4'h1;
            lock_q <= lock_q | (sp_q == SP_TOP);
        end else if (STK_REQ.pop) begin
            sp_q <= sp_q - 4'h1;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_top; STK_REQ.push |=> STK_TOP == $past(STK_REQ.pc); endproperty
    a_top: assert property (p_top)
        else $error("top is not pushed pc");
    property p_full; sp_q == SP_TOP |-> !STACK_AVAILABLE_FLAG; endproperty
    a_full: assert property (p_full)
        else $error("flag set at F");
    property p_lock; lock_q |-> !STACK_AVAILABLE_FLAG; endproperty
    a_lock: assert property (p_lock)
        else $error("flag set after wrap");
    property p_free; sp_q != SP_TOP && !lock_q |-> STACK_AVAILABLE_FLAG; endproperty
    a_free: assert property (p_free)
        else $error("flag clear");
    property p_valid; 1'b1 |=> IND_VALID == $past(IND_REQ.rd || IND_REQ.wr); endproperty
    a_valid: assert property (p_valid)
        else $error("valid not one cycle on");
    property p_zero; IND_ZERO_SET |-> IND_VALID && IND_RDATA == 8'h00; endproperty
    a_zero: assert property (p_zero)
        else $error("zero read not zero");
    property p_rd;
        MEM_REQ.rd |=> IND_VALID && !IND_ZERO_SET && IND_RDATA == $past(MEM_RDATA);
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data lost");
    property p_blk;
        MEM_REQ.rd || MEM_REQ.wr |-> MEM_REQ.addr != WIN0_ADDR && MEM_REQ.addr != WIN1_ADDR;
    endproperty
    a_blk: assert property (p_blk)
        else $error("window reached memory");
    c_wrap: cover property (STK_REQ.push && sp_q == SP_TOP);
    c_under: cover property (STK_REQ.pop && sp_q == SP_RESET);
    c_zs: cover property (IND_ZERO_SET);
endmodule
bind csia_core csia_core_asserts chk (.CLK(CLK), .RESET(RESET), .STK_REQ(STK_REQ),
    .STK_TOP(STK_TOP), .STACK_AVAILABLE_FLAG(STACK_AVAILABLE_FLAG), .IND_REQ(IND_REQ),
    .IND_RDATA(IND_RDATA), .IND_VALID(IND_VALID), .IND_ZERO_SET(IND_ZERO_SET),
    .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA));

/* sim/cpu_stack_and_indirect_addressing_test.sv */
// Bench of the stack and indirect core
`timescale 1ns/1ps
module cpu_stack_and_indirect_addressing_test;
    import csia_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] e; logic r;} csia_row_t;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, flag, ival, izs, perr;
    logic [7:0] paddr, irdata, mrdata, bank_seen;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] top;
    csia_stk_req_t sreq;
    csia_ind_req_t ireq;
    csia_mem_req_t mreq;
    csia_row_t rows [6];
    int err_total, check_count;
    csia_core uut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .STK_REQ(sreq), .STK_TOP(top), .STACK_AVAILABLE_FLAG(flag), .IND_REQ(ireq),
        .IND_RDATA(irdata), .IND_VALID(ival), .IND_ZERO_SET(izs), .MEM_REQ(mreq),
        .MEM_RDATA(mrdata));
    csia_ram_model ram (.clk(clk), .req(mreq), .rdata(mrdata));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task conclude;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // APB transfer, held until pready is sampled high
    task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t no pready", $time);
            conclude();
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One-cycle stack request
    task stk(input logic pu, input logic po, input logic [15:0] pc);
        @(posedge clk);
        sreq <= '{pu, po, pc};
        @(posedge clk);
        sreq <= '0;
        #1;
    endtask
    // One-cycle indirect request; bank seen in the request cycle
    task ind(input logic r, input logic w, input logic win, input logic [7:0] d);
        @(posedge clk);
        ireq <= '{r, w, win, d};
        #1 bank_seen = mreq.bank;
        @(posedge clk);
        ireq <= '0;
        #1;
    endtask
    initial begin
        #500000;
        err_total++;
        $display("[FAIL] %0t run timed out", $time);
        conclude();
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, sreq, ireq} = '0;
        reset = 1'b1;
        err_total = 0;
        check_count = 0;
        rows = '{'{OFS_PTR0, {24'h0, PTR_RESET}, 1'b0}, '{OFS_PTR1, {24'h0, PTR_RESET}, 1'b0},
            '{OFS_CTRL, {28'h0, MODES_RESET}, 1'b0}, '{OFS_STAT, {31'h0, AVAIL_RESET}, 1'b0},
            '{OFS_BANK, {24'h0, BANK_RESET}, 1'b0}, '{8'h14, 32'h0, 1'b1}};
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        // Register reset values and the unmapped slot
        foreach (rows[i]) begin
            ap(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
            chk(perr, rows[i].r);
        end
        // Fill to F, wrap, overwrite the oldest, pop back
        for (int i = 0; i < 16; i++) begin
            stk(1'b1, 1'b0, 16'h1000 + 16'(i));
            chk(top, 16'h1000 + 16'(i));
            chk(flag, 32'(i < 14));
        end
        stk(1'b1, 1'b0, 16'h2000);
        chk(top, 16'h2000);
        stk(1'b0, 1'b1, 16'h0);
        chk(top, 16'h100f);
        stk(1'b0, 1'b1, 16'h0);
        stk(1'b0, 1'b1, 16'h0);
        chk(top, 16'h100d);
        ap(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h0);
        // Reset mid-run, then pop before push
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        ap(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h1);
        // Flag register is read-only: a write is ignored without error
        ap(1'b1, OFS_STAT, 32'h0);
        chk(perr, 32'h0);
        ap(1'b0, OFS_STAT, 32'h0);
        chk(rd, 32'h1);
        stk(1'b0, 1'b1, 16'h0);
        chk(flag, 32'h0);
        stk(1'b1, 1'b0, 16'h3000);
        stk(1'b1, 1'b0, 16'h3001);
        chk(flag, 32'h0);
        // Indirect write through pointer 0, banked
        ap(1'b1, OFS_BANK, 32'h3);
        ap(1'b1, OFS_CTRL, 32'hd);
        ap(1'b1, OFS_PTR0, 32'h20);
        ind(1'b0, 1'b1, 1'b0, 8'h5a);
        chk(ram.mem[8'h20], 8'h5a);
        chk(bank_seen, 8'h03);
        chk(ival, 32'h1);
        // Every pointer mode
        for (int m = 0; m < 4; m++) begin
            ap(1'b1, OFS_PTR0, 32'h30);
            ap(1'b1, OFS_CTRL, 32'hc | 32'(m));
            ind(1'b1, 1'b0, 1'b0, 8'h0);
            chk(irdata, 8'h30 ^ 8'h5c);
            ap(1'b0, OFS_PTR0, 32'h0);
            chk(rd, (m == 0) ? 32'h2f : (m == 1) ? 32'h31 : 32'h30);
        end
        // Increment onto zero, then read through zero
        ap(1'b1, OFS_PTR0, 32'hff);
        ap(1'b1, OFS_CTRL, 32'hd);
        ind(1'b1, 1'b0, 1'b0, 8'h0);
        chk(izs, 32'h0);
        ind(1'b1, 1'b0, 1'b0, 8'h0);
        chk({izs, irdata}, {1'b1, 8'h00});
        // Pointer 1 aimed at its own window
        ap(1'b1, OFS_PTR1, 32'h8);
        ap(1'b1, OFS_CTRL, 32'h7);
        ind(1'b0, 1'b1, 1'b1, 8'h77);
        chk(izs, 32'h0);
        chk(ram.mem[WIN1_ADDR], WIN1_ADDR ^ 8'h5c);
        ind(1'b1, 1'b0, 1'b1, 8'h0);
        chk(irdata, 8'h09 ^ 8'h5c);
        ap(1'b1, OFS_PTR1, 32'h8);
        ind(1'b1, 1'b0, 1'b1, 8'h0);
        chk({izs, irdata}, {1'b1, 8'h00});
        conclude();
    end
endmodule
